// ### timer0_pkg.sv
// Shared constants and types for the timer 0 block and its clock front end
package timer0_pkg;

    // =====================================================================
    // Register map (byte addresses on the plain register port)
    localparam logic [2:0] ADDR_COUNT    = 3'h0;
    localparam logic [2:0] ADDR_COMPARE  = 3'h1;
    localparam logic [2:0] ADDR_MASK     = 3'h2;
    localparam logic [2:0] ADDR_FLAGS    = 3'h3;
    localparam logic [2:0] ADDR_SPECIAL  = 3'h4;
    localparam logic [2:0] ADDR_CONTROL0 = 3'h5;
    localparam logic [2:0] ADDR_CONTROL1 = 3'h6;

    // =====================================================================
    // Field positions
    localparam int OVF0_BIT      = 0;  // Mask and flag bit of overflow
    localparam int CMP0_BIT      = 1;  // Mask and flag bit of compare
    localparam int PRESC_RST_BIT = 0;  // Shared prescaler reset bit
    localparam int CS_LSB        = 0;  // Clock select field [2:0]
    localparam int MODE_LSB      = 3;  // Wave mode field [4:3]
    localparam int PIN_EN_BIT    = 5;  // Compare pin connect bit

    // =====================================================================
    // Reset values
    localparam logic [7:0] COUNT_RESET   = 8'h00;
    localparam logic [7:0] COMPARE_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET    = 8'h00;
    localparam logic [1:0] FLAGS_RESET   = 2'h0;
    localparam logic [6:0] SPECIAL_RESET = 7'h00;
    localparam logic [5:0] CONTROL_RESET = 6'h00;
    localparam logic [2:0] CS1_RESET     = 3'h0;
    localparam logic [9:0] PRESC_RESET   = 10'h000;

    // =====================================================================
    // Counter limits and clock select codes
    localparam logic [7:0] COUNT_MAX    = 8'hFF;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [2:0] CS_STOP      = 3'h0;
    localparam logic [2:0] CS_DIRECT    = 3'h1;
    localparam logic [2:0] CS_DIV8      = 3'h2;
    localparam logic [2:0] CS_DIV64     = 3'h3;
    localparam logic [2:0] CS_DIV256    = 3'h4;
    localparam logic [2:0] CS_DIV1024   = 3'h5;
    localparam logic [2:0] CS_EXT_FALL  = 3'h6;
    localparam logic [2:0] CS_EXT_RISE  = 3'h7;

    // Waveform modes
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_PHASE  = 2'b01,
        MODE_CTC    = 2'b10,
        MODE_FAST   = 2'b11
    } wave_mode_t;

endpackage

// ### timer0_prescaler_and_flags.sv
// Timer 0 counter, compare, flags, shared prescaler and count pin front end
`timescale 1ns/1ps

module timer0_prescaler_and_flags
    import timer0_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // Register port
    input  wire logic [2:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    // Core interrupt side
    input  wire logic       global_irq_enable,
    input  wire logic       compare0_vector_ack,
    input  wire logic       overflow0_vector_ack,
    output logic            compare0_irq_req,
    output logic            overflow0_irq_req,
    // External count pins
    input  wire logic       ext_count_pin_a,
    input  wire logic       ext_count_pin_b,
    // Timer outputs
    output logic            compare0_wave_pin,
    output logic            timer_a_tick,
    output logic            timer_b_tick
);

    // =====================================================================
    // State
    typedef struct packed {
        logic [7:0] count;
        logic [7:0] compare;
        logic [7:0] mask;
        logic [1:0] flags;
        logic [6:0] special;
        logic [5:0] control0;
        logic [2:0] cs1;
        logic [9:0] presc;
        logic       count_down;
        logic       block_match;
        logic [2:0] sync_a;
        logic [2:0] sync_b;
        logic [7:0] rdata;
        logic       cmp_req;
        logic       ovf_req;
        logic       wave;
        logic       tick_a;
        logic       tick_b;
    } state_t;

    state_t state;
    state_t next_state;

    // =====================================================================
    // Tick selection, shared by both timers
    function automatic logic select_tick(
        input logic [2:0] cs,
        input logic [9:0] presc,
        input logic       rise,
        input logic       fall
    );
        logic t;
        t = 1'b0;
        case (cs)
            CS_STOP:     t = 1'b0;
            CS_DIRECT:   t = 1'b1;
            CS_DIV8:     t = &presc[2:0];
            CS_DIV64:    t = &presc[5:0];
            CS_DIV256:   t = &presc[7:0];
            CS_DIV1024:  t = &presc[9:0];
            CS_EXT_FALL: t = fall;
            CS_EXT_RISE: t = rise;
            default:     t = 1'b0;
        endcase
        return t;
    endfunction

    // =====================================================================
    // Combinational decode
    logic       wr_count;
    logic       wr_compare;
    logic       wr_mask;
    logic       wr_flags;
    logic       wr_special;
    logic       wr_control0;
    logic       wr_control1;
    logic       rise_a;
    logic       fall_a;
    logic       rise_b;
    logic       fall_b;
    logic       tick;
    logic       match;
    logic       overflow;
    logic       clear_on_match;
    logic [7:0] count_step;
    logic       dir_step;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    wave_mode_t mode;

    // Write decodes
    assign wr_count    = reg_write && (reg_addr == ADDR_COUNT);
    assign wr_compare  = reg_write && (reg_addr == ADDR_COMPARE);
    assign wr_mask     = reg_write && (reg_addr == ADDR_MASK);
    assign wr_flags    = reg_write && (reg_addr == ADDR_FLAGS);
    assign wr_special  = reg_write && (reg_addr == ADDR_SPECIAL);
    assign wr_control0 = reg_write && (reg_addr == ADDR_CONTROL0);
    assign wr_control1 = reg_write && (reg_addr == ADDR_CONTROL1);

    // Edge detectors read only the second and third stages
    assign rise_a = state.sync_a[1] && !state.sync_a[2];
    assign fall_a = !state.sync_a[1] && state.sync_a[2];
    assign rise_b = state.sync_b[1] && !state.sync_b[2];
    assign fall_b = !state.sync_b[1] && state.sync_b[2];

    assign mode = wave_mode_t'(state.control0[MODE_LSB +: 2]);
    assign tick = select_tick(state.control0[CS_LSB +: 3], state.presc, rise_a, fall_a);

    // Compare is checked on every tick unless a count write blocked it
    assign match = tick && !state.block_match
                   && (state.count == state.compare);

    assign clear_on_match = match && (mode == MODE_CTC);

    // Next count and direction for the active mode
    always_comb begin
        count_step = state.count + 8'h01;
        dir_step   = state.count_down;
        overflow   = 1'b0;
        case (mode)
            MODE_PHASE: begin
                if (state.count_down) begin
                    if (state.count == COUNT_BOTTOM) begin
                        // Turn at bottom raises the overflow flag
                        dir_step   = 1'b0;
                        count_step = state.count + 8'h01;
                        overflow   = 1'b1;
                    end else begin
                        count_step = state.count - 8'h01;
                    end
                end else if (state.count == COUNT_MAX) begin
                    dir_step   = 1'b1;
                    count_step = state.count - 8'h01;
                end
            end
            MODE_CTC: begin
                overflow = (state.count == COUNT_MAX);
                if (clear_on_match) begin
                    count_step = COUNT_BOTTOM;
                end
            end
            MODE_NORMAL,
            MODE_FAST: begin
                overflow = (state.count == COUNT_MAX);
                dir_step = 1'b0;
            end
            default: begin
                overflow = 1'b0;
            end
        endcase
    end

    // Flag sources; hardware set always beats a clear
    assign flag_set[CMP0_BIT] = match;
    assign flag_set[OVF0_BIT] = tick && overflow;
    assign flag_clr[CMP0_BIT] = compare0_vector_ack
                                || (wr_flags && reg_wdata[CMP0_BIT]);
    assign flag_clr[OVF0_BIT] = overflow0_vector_ack
                                || (wr_flags && reg_wdata[OVF0_BIT]);

    // =====================================================================
    // Next state
    always_comb begin
        next_state = state;

        // Count pin samplers, one stage per rising clock edge
        // Three stages give the pin-edge-to-count latency of about three cycles
        next_state.sync_a = {state.sync_a[1:0], ext_count_pin_a};
        next_state.sync_b = {state.sync_b[1:0], ext_count_pin_b};

        // Free running prescaler; its reset restarts both timers' taps
        if (wr_special && reg_wdata[PRESC_RST_BIT]) begin
            next_state.presc = PRESC_RESET;
        end else begin
            next_state.presc = state.presc + 10'h001;
        end

        // Counter advance, then a core write overrides it
        if (tick) begin
            next_state.count       = count_step;
            next_state.count_down  = dir_step;
            next_state.block_match = 1'b0;
        end
        if (wr_count) begin
            next_state.count       = reg_wdata;
            next_state.block_match = 1'b1;
        end

        // Plain register writes
        if (wr_compare) begin
            next_state.compare = reg_wdata;
        end
        if (wr_mask) begin
            next_state.mask = reg_wdata;
        end
        if (wr_special) begin
            next_state.special = reg_wdata[7:1];
        end
        if (wr_control0) begin
            next_state.control0 = reg_wdata[5:0];
        end
        if (wr_control1) begin
            next_state.cs1 = reg_wdata[2:0];
        end

        // Sticky flags
        next_state.flags = (state.flags & ~flag_clr) | flag_set;

        // Requests follow the flag, mask and global enable
        next_state.cmp_req = next_state.flags[CMP0_BIT] && state.mask[CMP0_BIT]
                             && global_irq_enable;
        next_state.ovf_req = next_state.flags[OVF0_BIT] && state.mask[OVF0_BIT]
                             && global_irq_enable;

        // Compare driven wave pin, held low while disconnected
        if (!state.control0[PIN_EN_BIT]) begin
            next_state.wave = 1'b0;
        end else if (match) begin
            case (mode)
                MODE_FAST:  next_state.wave = 1'b0;
                MODE_PHASE: next_state.wave = state.count_down;
                default:    next_state.wave = !state.wave;
            endcase
        end else if (tick && (mode == MODE_FAST) && (state.count == COUNT_MAX)) begin
            next_state.wave = 1'b1;
        end

        // Tick strobes for observers and the second timer
        next_state.tick_a = tick;
        next_state.tick_b = select_tick(state.cs1, state.presc, rise_b, fall_b);

        // Read data stands in the cycle after the strobe only
        next_state.rdata = 8'h00;
        if (reg_read) begin
            case (reg_addr)
                ADDR_COUNT:    next_state.rdata = state.count;
                ADDR_COMPARE:  next_state.rdata = state.compare;
                ADDR_MASK:     next_state.rdata = state.mask;
                ADDR_FLAGS:    next_state.rdata = {6'h00, state.flags};
                ADDR_SPECIAL:  next_state.rdata = {state.special, 1'b0};
                ADDR_CONTROL0: next_state.rdata = {2'h0, state.control0};
                ADDR_CONTROL1: next_state.rdata = {5'h00, state.cs1};
                default:       next_state.rdata = 8'h00;
            endcase
        end
    end

    // =====================================================================
    // State register
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state.count       <= COUNT_RESET;
            state.compare     <= COMPARE_RESET;
            state.mask        <= MASK_RESET;
            state.flags       <= FLAGS_RESET;
            state.special     <= SPECIAL_RESET;
            state.control0    <= CONTROL_RESET;
            state.cs1         <= CS1_RESET;
            state.presc       <= PRESC_RESET;
            state.count_down  <= 1'b0;
            state.block_match <= 1'b0;
            state.sync_a      <= 3'h0;
            state.sync_b      <= 3'h0;
            state.rdata       <= 8'h00;
            state.cmp_req     <= 1'b0;
            state.ovf_req     <= 1'b0;
            state.wave        <= 1'b0;
            state.tick_a      <= 1'b0;
            state.tick_b      <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // =====================================================================
    // Outputs, all straight from flip-flops
    assign reg_rdata         = state.rdata;
    assign compare0_irq_req  = state.cmp_req;
    assign overflow0_irq_req = state.ovf_req;
    assign compare0_wave_pin = state.wave;
    assign timer_a_tick      = state.tick_a;
    assign timer_b_tick      = state.tick_b;

endmodule

// ### count_source.sv
// Behavioural external count source for the timer count pins
`timescale 1ns/1ps
// ==========================================================
// Count source model
module count_source (
    // Clock and control
    input  wire logic sys_clk,
    input  wire logic run,
    // Count pin
    output logic      pin
);
    logic [1:0] phase = 2'h0;

    // Toggle every third cycle; the level holds still while idle so select changes are safe
    initial pin = 1'b0;
    always @(posedge sys_clk) begin
        if (run) begin
            phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
            if (phase == 2'h2) begin
                pin <= !pin;
            end
        end
    end
endmodule

// ### timer0_properties.sv
// Concurrent checks on the timer 0 block ports
`timescale 1ns/1ps
// ==========================================================
// Port checker
module timer0_properties
    import timer0_pkg::*;
(
    // Clock and reset
    input wire logic       sys_clk,
    input wire logic       reset,
    // Register port
    input wire logic [2:0] reg_addr,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    // Interrupt side
    input wire logic       global_irq_enable,
    input wire logic       compare0_vector_ack,
    input wire logic       overflow0_vector_ack,
    input wire logic       compare0_irq_req,
    input wire logic       overflow0_irq_req
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    // Read slot and read-only fields
    rdata_idle_a: assert property (
        !$past(reg_read) |-> reg_rdata == 8'h00) else $error("read data outside read slot");
    presc_zero_a: assert property (
        $past(reg_read) && $past(reg_addr) == ADDR_SPECIAL |-> !reg_rdata[PRESC_RST_BIT])
        else $error("prescaler reset bit read as one");
    flags_upper_a: assert property (
        $past(reg_read) && $past(reg_addr) == ADDR_FLAGS |-> reg_rdata[7:2] == 6'h00)
        else $error("unused flag bits read as one");
    unmapped_zero_a: assert property (
        $past(reg_read) && $past(reg_addr) == 3'h7 |-> reg_rdata == 8'h00)
        else $error("unmapped address read nonzero");

    // Requests need the global enable; they only drop for a clear or a gate
    cmp_global_a: assert property (
        !global_irq_enable |=> !compare0_irq_req) else $error("compare request without enable");
    ovf_global_a: assert property (
        !global_irq_enable |=> !overflow0_irq_req) else $error("overflow request without enable");
    cmp_clear_a: assert property (
        $fell(compare0_irq_req) && !$past(reset) |->
        $past(compare0_vector_ack) || $past(reg_write) || !$past(global_irq_enable))
        else $error("compare request dropped without cause");
    ovf_clear_a: assert property (
        $fell(overflow0_irq_req) && !$past(reset) |->
        $past(overflow0_vector_ack) || $past(reg_write) || !$past(global_irq_enable))
        else $error("overflow request dropped without cause");
endmodule

// ### testbench.sv
// Self-checking testbench for the timer 0 block
`timescale 1ns/1ps
// ==========================================================
// Top level
module testbench;
    import timer0_pkg::*;
    localparam logic [2:0] AMAP [5] = '{ADDR_COUNT, ADDR_COMPARE, ADDR_MASK, ADDR_SPECIAL, 3'h7};
    localparam int         DIVS [6] = '{0, 1, 8, 64, 256, 1024};
    logic        sys_clk = 1'b0;
    logic        reset = 1'b1;
    logic [2:0]  reg_addr = 3'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [7:0]  reg_rdata;
    logic        global_irq_enable = 1'b0;
    logic        cmp_ack = 1'b0;
    logic        ovf_ack = 1'b0;
    logic [1:0]  req;
    logic        run = 1'b0;
    logic        pin;
    logic        wave;
    logic        tick_a;
    logic        tick_b;
    int          na = 0;
    int          nb = 0;
    logic [31:0] seed = 32'h27;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          rises = 0;
    int          falls = 0;

    count_source i_count_source (.sys_clk, .run, .pin);
    timer0_prescaler_and_flags i_timer0_prescaler_and_flags (
        .sys_clk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .global_irq_enable, .compare0_vector_ack(cmp_ack), .overflow0_vector_ack(ovf_ack),
        .compare0_irq_req(req[1]), .overflow0_irq_req(req[0]), .ext_count_pin_a(pin),
        .ext_count_pin_b(pin), .compare0_wave_pin(wave), .timer_a_tick(tick_a),
        .timer_b_tick(tick_b));

    // Clock and pin edge counters
    always #10 sys_clk = ~sys_clk;
    always @(posedge pin) rises++;
    always @(negedge pin) falls++;
    // Tick strobes counted at the edge, before the design updates them
    always @(posedge sys_clk) begin
        na += int'(tick_a);
        nb += int'(tick_b);
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic cycle(input logic w, input logic r, input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_write <= w;
        reg_read <= r;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        cycle(1'b1, 1'b0, a, d);
        cycle(1'b0, 1'b0, a, d);
    endtask

    // Ends just past the edge so registered outputs have landed
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic chk_rd(input string what, input logic [2:0] a, input logic [7:0] exp);
        cycle(1'b0, 1'b1, a, 8'h00);
        cycle(1'b0, 1'b0, a, 8'h00);
        #1;
        check(what, exp, reg_rdata);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog in case the sequence stalls
    initial begin
        #2000000;
        n_mismatch++;
        results();
    end

    // Main sequence
    initial begin
        logic [7:0] r;
        logic [2:0] a;
        int         j;
        int         ta;
        int         tb;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            chk_rd("reset value", 3'(k), 8'h00);
        end
        for (int k = 0; k < 15; k++) begin
            seed = xs(seed);
            r = seed[7:0];
            a = AMAP[k % 5];
            wr(a, r);
            chk_rd("read back", a, (a == 3'h7) ? 8'h00 : (a == ADDR_SPECIAL) ? r & 8'hFE : r);
        end
        $display("test registers done");
        // Prescaler restarted, then counted over two and a half divider periods, or five cycles when stopped or direct
        for (int c = 0; c < 6; c++) begin
            seed = xs(seed);
            r = seed[7:0] & 8'h7F;
            j = (c < 2) ? 5 : DIVS[c] * 5 / 2 - 4;
            wr(ADDR_CONTROL0, 8'(c));
            wr(ADDR_SPECIAL, 8'h01);
            wr(ADDR_COUNT, r);
            idle(j);
            chk_rd("count", ADDR_COUNT, (c == 0) ? r : r + ((c == 1) ? 8'(j + 1) : 8'h02));
        end
        $display("test prescaler done");
        wr(ADDR_CONTROL0, 8'(CS_STOP));
        global_irq_enable <= 1'b1;
        wr(ADDR_MASK, 8'h03);
        wr(ADDR_COMPARE, 8'h80);
        // Bit 0 overflow, bit 1 compare; upper index bit picks vector or write clear
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_COUNT, i[0] ? 8'h7F : 8'hFF);
            wr(ADDR_FLAGS, 8'h03);
            wr(ADDR_CONTROL0, 8'(CS_DIRECT));
            idle(1);
            wr(ADDR_CONTROL0, 8'(CS_STOP));
            idle(1);
            check("request", 8'(1 << i[0]), 8'(req));
            chk_rd("flags", ADDR_FLAGS, 8'(1 << i[0]));
            global_irq_enable <= 1'b0;
            idle(2);
            check("gated request", 8'h00, 8'(req));
            global_irq_enable <= 1'b1;
            idle(2);
            check("request", 8'(1 << i[0]), 8'(req));
            if (i[1]) begin
                cmp_ack <= i[0];
                ovf_ack <= !i[0];
                idle(1);
                cmp_ack <= 1'b0;
                ovf_ack <= 1'b0;
            end else begin
                wr(ADDR_FLAGS, 8'(1 << i[0]));
            end
            idle(2);
            check("cleared request", 8'h00, 8'(req));
            chk_rd("cleared flags", ADDR_FLAGS, 8'h00);
        end
        $display("test flags done");
        wr(ADDR_COMPARE, 8'h40);
        wr(ADDR_COUNT, 8'h40);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_CONTROL0, 8'(CS_DIRECT));
        wr(ADDR_CONTROL0, 8'(CS_STOP));
        chk_rd("suppressed match", ADDR_FLAGS, 8'h00);
        $display("test suppression done");
        // Phase mode: no overflow at the top turn, only when leaving bottom
        wr(ADDR_COMPARE, 8'h80);
        wr(ADDR_COUNT, 8'hFE);
        wr(ADDR_FLAGS, 8'h03);
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_CONTROL0, 8'h09);
            idle(p ? 300 : 4);
            wr(ADDR_CONTROL0, 8'h08);
            chk_rd("phase flags", ADDR_FLAGS, p ? 8'h03 : 8'h00);
        end
        // Clear on match with the pin connected: six ticks, one toggle
        wr(ADDR_COMPARE, 8'h03);
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CONTROL0, 8'h31);
        idle(4);
        wr(ADDR_CONTROL0, 8'h30);
        check("wave pin", 8'h01, {7'h00, wave});
        chk_rd("ctc count", ADDR_COUNT, 8'h02);
        $display("test modes done");
        // Pin edges counted one for one, rising then falling
        for (int e = 0; e < 2; e++) begin
            wr(ADDR_CONTROL0, e ? 8'(CS_EXT_FALL) : 8'(CS_EXT_RISE));
            wr(ADDR_CONTROL1, e ? 8'(CS_EXT_FALL) : 8'(CS_EXT_RISE));
            wr(ADDR_COUNT, 8'h00);
            j = e ? falls : rises;
            ta = na;
            tb = nb;
            run <= 1'b1;
            idle(40);
            run <= 1'b0;
            idle(6);
            chk_rd("pin count", ADDR_COUNT, 8'((e ? falls : rises) - j));
            check("tick a", 8'((e ? falls : rises) - j), 8'(na - ta));
            check("tick b", 8'((e ? falls : rises) - j), 8'(nb - tb));
        end
        $display("test count pin done");
        results();
    end
endmodule

bind timer0_prescaler_and_flags timer0_properties i_timer0_properties (
    .sys_clk, .reset, .reg_addr, .reg_write, .reg_read, .reg_rdata, .global_irq_enable,
    .compare0_vector_ack, .overflow0_vector_ack, .compare0_irq_req, .overflow0_irq_req);
